// ==== rtl/wgt_pkg.sv ====
// Purpose: Shared constants for the windowed guard timer.
// Assumes: A 10 MHz system clock and a free-running guard oscillator.
// Notes: Feed pattern bytes and reset pulse length are local choices.
package wgt_pkg;
    localparam int unsigned WGT_COUNT_W = 24;
    localparam int unsigned WGT_PRESCALE = 4;
    localparam int unsigned WGT_PRE_W = 2;
    localparam logic [23:0] WGT_MIN_RELOAD = 24'h0000ff;
    localparam logic [23:0] WGT_RELOAD_RST = 24'hffffff;
    localparam logic [23:0] WGT_WINDOW_RST = 24'hffffff;
    localparam logic [23:0] WGT_WARN_RST = 24'h000000;
    localparam logic [7:0] WGT_FEED_FIRST = 8'haa;
    localparam logic [7:0] WGT_FEED_SECOND = 8'h55;
    localparam logic [2:0] WGT_RESET_HOLD = 3'h4;
    localparam int unsigned WGT_CLK_HZ = 10000000;
    localparam int unsigned WGT_GUARD_HZ = 500000;
    // Each guard half-period must span at least two system clocks.
    localparam int unsigned WGT_CLK_PER_GUARD = WGT_CLK_HZ / WGT_GUARD_HZ;
endpackage : wgt_pkg

// ==== rtl/wgt_tick_gen.sv ====
// Purpose: Brings the guard oscillator into the system clock domain.
// Assumes: The guard clock is far slower than clk_in.
// Notes: Emits one pulse per four guard clock rising edges while run_in is high.
`timescale 1ns/1ps
`default_nettype none
module wgt_tick_gen
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic guard_tick_clock_in,
    input wire logic run_in,
    output logic tick_out
);
    import wgt_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic last_q;
    logic [WGT_PRE_W-1:0] pre_q;
    logic [WGT_PRE_W-1:0] pre_d;
    logic tick_q;
    logic tick_d;
    logic edge_seen;
    logic [2:0] edges_q;
    logic [2:0] edges_d;

    always_comb
    begin
        pre_d = pre_q;
        tick_d = 1'b0;
        edge_seen = run_in && sync2_q && !last_q;
        // Edge tally kept apart from the prescaler so its check is independent.
        edges_d = tick_q ? 3'h0 : edges_q;
        if (edge_seen)
        begin
            pre_d = pre_q + WGT_PRE_W'(1);
            tick_d = (pre_q == WGT_PRE_W'(WGT_PRESCALE - 1));
            edges_d = edges_d + 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q <= 1'b0;
            pre_q <= '0;
            tick_q <= 1'b0;
            edges_q <= 3'h0;
        end
        else
        begin
            sync1_q <= guard_tick_clock_in;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
            pre_q <= pre_d;
            tick_q <= tick_d;
            edges_q <= edges_d;
        end
    end

    assign tick_out = tick_q;

    chk_tick_spacing: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        tick_q |-> ##1 (!tick_q) [*8])
    else $error("Guard ticks arrive closer than the prescaler allows.");

    chk_tick_edges: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        tick_q |-> (edges_q == 3'(WGT_PRESCALE)))
    else $error("Guard tick did not follow four guard clock edges.");
endmodule : wgt_tick_gen
`default_nettype wire

// ==== rtl/wgt_guard.sv ====
// Purpose: Windowed guard timer that resets the chip when not serviced.
// Assumes: Control inputs come from logic on clk_in; the guard clock does not.
// Notes: arst_n_in is the hardware reset; a guard-caused reset is internal.
`timescale 1ns/1ps
`default_nettype none
module wgt_guard
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic guard_tick_clock_in,
    input wire logic cfg_write_in,
    input wire logic cfg_reset_mode_in,
    input wire logic cfg_window_mode_in,
    input wire logic cfg_protect_in,
    input wire logic cfg_warn_enable_in,
    input wire logic cfg_run_in_sleep_in,
    input wire logic [23:0] cfg_window_in,
    input wire logic [23:0] cfg_warn_in,
    input wire logic enable_set_in,
    input wire logic reload_write_in,
    input wire logic [23:0] reload_value_in,
    input wire logic feed_write_in,
    input wire logic [7:0] feed_data_in,
    input wire logic guard_access_in,
    input wire logic sleep_in,
    input wire logic debug_halt_in,
    input wire logic warn_clear_in,
    input wire logic timeout_clear_in,
    input wire logic reset_flag_clear_in,
    output logic chip_reset_out,
    output logic enabled_out,
    output logic warn_flag_out,
    output logic timeout_flag_out,
    output logic reset_flag_out,
    output logic [23:0] count_out
);
    import wgt_pkg::*;

    function automatic logic [23:0] clamp_reload(input logic [23:0] v);
        clamp_reload = (v < WGT_MIN_RELOAD) ? WGT_MIN_RELOAD : v;
    endfunction : clamp_reload

    logic tick;
    logic run;
    logic enabled_q, enabled_d;
    logic reset_mode_q, reset_mode_d;
    logic window_mode_q, window_mode_d;
    logic protect_q, protect_d;
    logic warn_en_q, warn_en_d;
    logic run_sleep_q, run_sleep_d;
    logic [23:0] window_q, window_d;
    logic [23:0] warn_q, warn_d;
    logic [23:0] reload_q, reload_d;
    logic [23:0] count_q, count_d;
    logic armed_q, armed_d;
    logic warn_flag_q, warn_flag_d;
    logic timeout_q, timeout_d;
    logic rflag_q, rflag_d;
    logic [2:0] hold_q, hold_d;
    logic chip_reset_q, chip_reset_d;
    logic expire;
    logic good_feed;
    logic feed_fault;
    logic fire;

    // Halting under the debugger keeps a breakpoint from resetting the chip.
    assign run = enabled_q && !debug_halt_in
        && (!sleep_in || run_sleep_q);

    wgt_tick_gen u_tick
    (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .guard_tick_clock_in(guard_tick_clock_in),
        .run_in(run),
        .tick_out(tick)
    );

    always_comb
    begin
        expire = run && tick && (count_q == 24'h000000);
        good_feed = 1'b0;
        feed_fault = 1'b0;
        armed_d = armed_q;
        if (feed_write_in)
        begin
            if (!armed_q)
            begin
                armed_d = (feed_data_in == WGT_FEED_FIRST);
                feed_fault = (feed_data_in != WGT_FEED_FIRST);
            end
            else
            begin
                armed_d = 1'b0;
                if (feed_data_in != WGT_FEED_SECOND)
                    feed_fault = 1'b1;
                else if (window_mode_q && count_q > window_q)
                    feed_fault = 1'b1;
                else
                    good_feed = 1'b1;
            end
        end
        else if (guard_access_in && armed_q)
        begin
            armed_d = 1'b0;
            feed_fault = 1'b1;
        end
        // A fault only matters once the guard is enabled; before that it is ignored.
        fire = enabled_q && (expire || feed_fault);
        // A guard reset also drops a half-done feed.
        if (fire && reset_mode_q)
            armed_d = 1'b0;
    end

    always_comb
    begin
        enabled_d = enabled_q;
        reset_mode_d = reset_mode_q;
        window_mode_d = window_mode_q;
        protect_d = protect_q;
        warn_en_d = warn_en_q;
        run_sleep_d = run_sleep_q;
        window_d = window_q;
        warn_d = warn_q;
        reload_d = reload_q;
        count_d = count_q;
        warn_flag_d = warn_flag_q;
        timeout_d = timeout_q;
        rflag_d = rflag_q;
        hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
        if (cfg_write_in && !enabled_q)
        begin
            reset_mode_d = cfg_reset_mode_in;
            window_mode_d = cfg_window_mode_in;
            protect_d = cfg_protect_in;
            warn_en_d = cfg_warn_enable_in;
            run_sleep_d = cfg_run_in_sleep_in;
            window_d = cfg_window_in;
            warn_d = cfg_warn_in;
        end
        if (reload_write_in && !(protect_q && enabled_q && count_q > warn_q))
            reload_d = clamp_reload(reload_value_in);
        if (warn_clear_in)
            warn_flag_d = 1'b0;
        if (timeout_clear_in)
            timeout_d = 1'b0;
        if (reset_flag_clear_in)
            rflag_d = 1'b0;
        if (run && tick && warn_en_q && count_q == warn_q)
            warn_flag_d = 1'b1;
        if (enable_set_in && !enabled_q && hold_q == 3'h0)
        begin
            enabled_d = 1'b1;
            count_d = reload_q;
        end
        else if (fire && reset_mode_q)
        begin
            // The guard clears its enable and settings as part of the reset it causes; the count and timeout flag keep their values.
            enabled_d = 1'b0;
            reset_mode_d = 1'b0;
            window_mode_d = 1'b0;
            protect_d = 1'b0;
            warn_en_d = 1'b0;
            run_sleep_d = 1'b0;
            window_d = WGT_WINDOW_RST;
            warn_d = WGT_WARN_RST;
            reload_d = WGT_RELOAD_RST;
            warn_flag_d = 1'b0;
            hold_d = WGT_RESET_HOLD;
            rflag_d = 1'b1;
        end
        else if (fire)
        begin
            timeout_d = 1'b1;
            count_d = reload_q;
        end
        else if (good_feed && enabled_q)
            count_d = reload_q;
        else if (run && tick)
            count_d = count_q - 24'h000001;
        chip_reset_d = (hold_d != 3'h0);
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            enabled_q <= 1'b0;
            reset_mode_q <= 1'b0;
            window_mode_q <= 1'b0;
            protect_q <= 1'b0;
            warn_en_q <= 1'b0;
            run_sleep_q <= 1'b0;
            window_q <= WGT_WINDOW_RST;
            warn_q <= WGT_WARN_RST;
            reload_q <= WGT_RELOAD_RST;
            count_q <= WGT_RELOAD_RST;
            armed_q <= 1'b0;
            warn_flag_q <= 1'b0;
            timeout_q <= 1'b0;
            rflag_q <= 1'b0;
            hold_q <= 3'h0;
            chip_reset_q <= 1'b0;
        end
        else
        begin
            enabled_q <= enabled_d;
            reset_mode_q <= reset_mode_d;
            window_mode_q <= window_mode_d;
            protect_q <= protect_d;
            warn_en_q <= warn_en_d;
            run_sleep_q <= run_sleep_d;
            window_q <= window_d;
            warn_q <= warn_d;
            reload_q <= reload_d;
            count_q <= count_d;
            armed_q <= armed_d;
            warn_flag_q <= warn_flag_d;
            timeout_q <= timeout_d;
            rflag_q <= rflag_d;
            hold_q <= hold_d;
            chip_reset_q <= chip_reset_d;
        end
    end

    assign chip_reset_out = chip_reset_q;
    assign enabled_out = enabled_q;
    assign warn_flag_out = warn_flag_q;
    assign timeout_flag_out = timeout_q;
    assign reset_flag_out = rflag_q;
    assign count_out = count_q;

    chk_expire_resets: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (expire && reset_mode_q) |-> ##1 (chip_reset_q && !enabled_q))
    else $error("Expiry in reset mode did not reset the chip.");

    chk_reset_hold: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(chip_reset_q) |-> chip_reset_q [*4] ##1 !chip_reset_q)
    else $error("Chip reset pulse has the wrong length.");

    chk_window_fault: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (enabled_q && window_mode_q && feed_write_in && armed_q
            && feed_data_in == WGT_FEED_SECOND && count_q > window_q)
        |-> ##1 (chip_reset_q || timeout_q))
    else $error("Early feed in windowed mode was not a fault.");

    chk_warn_set: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (run && tick && warn_en_q && count_q == warn_q && !fire)
        |-> ##1 warn_flag_q)
    else $error("Warning flag missed the warn point.");

    chk_min_reload: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        reload_q >= WGT_MIN_RELOAD)
    else $error("Reload value fell below the least time-out.");

    chk_enable_sticky: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (enabled_q && !(fire && reset_mode_q)) |-> ##1 enabled_q)
    else $error("Guard dropped its enable without a reset.");

    chk_bad_feed: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (enabled_q && feed_write_in && !armed_q
            && feed_data_in != WGT_FEED_FIRST)
        |-> ##1 (chip_reset_q || timeout_q))
    else $error("Wrong feed byte did not raise a guard event.");

    chk_protect_hold: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (reload_write_in && protect_q && enabled_q && count_q > warn_q
            && !fire) |-> ##1 $stable(reload_q))
    else $error("Protected reload value changed too early.");

    chk_flag_on_reset: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(chip_reset_q) |-> rflag_q)
    else $error("Reset flag not set by a guard reset.");

    chk_config_lock: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (enabled_q && !fire) |-> ##1 ($stable(window_q) && $stable(warn_q)
            && $stable(window_mode_q) && $stable(reset_mode_q)))
    else $error("Configuration changed while locked.");

    chk_feed_reload: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (good_feed && enabled_q && !fire && !reload_write_in)
        |-> ##1 (count_q == reload_q))
    else $error("Correct feed did not reload the counter.");

    chk_debug_halt: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (debug_halt_in && enabled_q && !feed_write_in && !guard_access_in)
        |-> ##1 $stable(count_q))
    else $error("Counter moved while the debugger halted the core.");
endmodule : wgt_guard
`default_nettype wire

// ==== verification/windowed_guard_timer_test.sv ====
// Purpose: Self-checking bench for the windowed guard timer.
// Assumes: Inputs change at the falling edge of clk_in.
// Notes: The guard clock runs at 500 kHz, so one count step takes 80 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    err_count++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module windowed_guard_timer_test;
    import wgt_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic gclk = 1'b0;
    logic cfg_write = 1'b0, rm = 1'b0, wm = 1'b0, pr = 1'b0;
    logic we = 1'b0, rs = 1'b0, en_set = 1'b0, rl_wr = 1'b0;
    logic fd_wr = 1'b0, acc = 1'b0, slp = 1'b0, halt = 1'b0;
    logic wclr = 1'b0, tclr = 1'b0, rclr = 1'b0;
    logic [23:0] win = 24'h000000, warn = 24'h000000, rl = 24'h000000;
    logic [7:0] fd = 8'h00;
    logic chip_rst, en, wflag, tflag, rflag;
    logic [23:0] cnt;
    int err_count = 0;
    int checks_done = 0;

    wgt_guard u_dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .guard_tick_clock_in(gclk),
        .cfg_write_in(cfg_write), .cfg_reset_mode_in(rm),
        .cfg_window_mode_in(wm), .cfg_protect_in(pr),
        .cfg_warn_enable_in(we), .cfg_run_in_sleep_in(rs),
        .cfg_window_in(win), .cfg_warn_in(warn), .enable_set_in(en_set),
        .reload_write_in(rl_wr), .reload_value_in(rl),
        .feed_write_in(fd_wr), .feed_data_in(fd), .guard_access_in(acc),
        .sleep_in(slp), .debug_halt_in(halt), .warn_clear_in(wclr),
        .timeout_clear_in(tclr), .reset_flag_clear_in(rclr),
        .chip_reset_out(chip_rst), .enabled_out(en), .warn_flag_out(wflag),
        .timeout_flag_out(tflag), .reset_flag_out(rflag), .count_out(cnt)
    );

    initial forever #50 clk_in = ~clk_in;

    // Odd start offset keeps the guard clock out of phase with clk_in.
    initial
    begin
        #37;
        forever #1000 gclk = ~gclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    initial
    begin
        #(60000 * 100);
        err_count++;
        $display("[ERR] run_time expected finish seen timeout");
        test_done();
    end

    // A pulse ends one edge later, so callers never set it twice at once.
    task automatic pulse(ref logic s);
        @(negedge clk_in);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
    endtask : pulse

    task automatic feed(input logic [7:0] b);
        @(negedge clk_in);
        fd = b;
        fd_wr = 1'b1;
        @(negedge clk_in);
        fd_wr = 1'b0;
    endtask : feed

    task automatic do_reset();
        @(negedge clk_in);
        arst_n_in = 1'b0;
        repeat (3) @(negedge clk_in);
        arst_n_in = 1'b1;
        @(negedge clk_in);
        `CHK("enabled_rst", 1'b0, en)
        `CHK("count_rst", 24'hffffff, cnt)
        `CHK("chip_reset_rst", 1'b0, chip_rst)
    endtask : do_reset

    task automatic configure(input logic [4:0] m, input logic [23:0] w,
        input logic [23:0] wn, input logic [23:0] r);
        logic [23:0] exp_cnt;
        {rm, wm, pr, we, rs} = m;
        win = w;
        warn = wn;
        rl = r;
        exp_cnt = (r < WGT_MIN_RELOAD) ? WGT_MIN_RELOAD : r;
        pulse(cfg_write);
        pulse(rl_wr);
        pulse(en_set);
        `CHK("enabled", 1'b1, en)
        `CHK("start_count", exp_cnt, cnt)
    endtask : configure

    task automatic wait_le(input logic [23:0] v);
        int n;
        n = 0;
        while (cnt > v && n < 30000)
        begin
            @(negedge clk_in);
            n++;
        end
        `CHK("count_reached", 1'b1, (n < 30000) && (cnt <= v))
    endtask : wait_le

    task automatic tick_gap(output int gap);
        logic [23:0] c;
        c = cnt;
        gap = 0;
        while (cnt === c && gap < 200)
        begin
            @(negedge clk_in);
            gap++;
        end
    endtask : tick_gap

    task automatic hold(ref logic s, input logic moves);
        logic [23:0] c;
        c = cnt;
        s = 1'b1;
        repeat (200) @(negedge clk_in);
        s = 1'b0;
        `CHK("count_moves", moves, cnt != c)
    endtask : hold

    task automatic expect_reset(input int lim);
        int w;
        int n;
        w = 0;
        n = 0;
        while (chip_rst !== 1'b1 && w < lim)
        begin
            @(negedge clk_in);
            w++;
        end
        while (chip_rst === 1'b1 && n < 20)
        begin
            @(negedge clk_in);
            n++;
        end
        `CHK("reset_seen", 1'b1, w < lim)
        `CHK("reset_len", 4, n)
        `CHK("reset_flag", 1'b1, rflag)
        `CHK("enabled_off", 1'b0, en)
    endtask : expect_reset

    initial
    begin
        int g;
        logic [23:0] c;
        do_reset();
        $display("test reset done");
        configure(5'b11010, 24'h0000f0, 24'h0000fa, 24'h000010);
        tick_gap(g);
        c = cnt;
        tick_gap(g);
        `CHK("tick_gap", 80, g)
        `CHK("tick_step", c - 24'h1, cnt)
        wait_le(24'h0000fa);
        `CHK("warn_early", 1'b0, wflag)
        wait_le(24'h0000f9);
        `CHK("warn_set", 1'b1, wflag)
        pulse(wclr);
        `CHK("warn_clear", 1'b0, wflag)
        feed(WGT_FEED_FIRST);
        feed(WGT_FEED_SECOND);
        expect_reset(10);
        pulse(rclr);
        `CHK("reset_flag_clr", 1'b0, rflag)
        $display("test window_warn done");
        do_reset();
        configure(5'b11100, 24'h0000f0, 24'h0000fa, 24'h0000ff);
        rl = 24'h0001ff;
        pulse(rl_wr);
        hold(slp, 1'b0);
        hold(halt, 1'b0);
        wait_le(24'h0000f0);
        feed(WGT_FEED_FIRST);
        feed(WGT_FEED_SECOND);
        `CHK("protected_reload", 24'h0000ff, cnt)
        wait_le(24'h0000f0);
        pulse(rl_wr);
        feed(WGT_FEED_FIRST);
        feed(WGT_FEED_SECOND);
        `CHK("new_reload", 24'h0001ff, cnt)
        `CHK("no_reset", 1'b0, chip_rst)
        $display("test protect done");
        do_reset();
        configure(5'b00001, 24'hffffff, 24'h000000, 24'h000300);
        hold(slp, 1'b1);
        rm = 1'b1;
        pulse(cfg_write);
        for (int k = 0; k < 3; k++)
        begin
            if (k == 0)
                feed(8'h12);
            else
                feed(WGT_FEED_FIRST);
            if (k == 1)
                feed(8'h12);
            if (k == 2)
                pulse(acc);
            repeat (3) @(negedge clk_in);
            `CHK("timeout_flag", 1'b1, tflag)
            `CHK("no_chip_reset", 1'b0, chip_rst)
            `CHK("still_enabled", 1'b1, en)
            pulse(tclr);
            `CHK("timeout_clr", 1'b0, tflag)
        end
        feed(WGT_FEED_FIRST);
        feed(WGT_FEED_SECOND);
        repeat (3) @(negedge clk_in);
        `CHK("good_feed", 1'b0, tflag)
        $display("test feed_faults done");
        do_reset();
        configure(5'b10000, 24'hffffff, 24'h000000, 24'h000000);
        expect_reset(30000);
        $display("test expiry done");
        test_done();
    end
endmodule : windowed_guard_timer_test
`default_nettype wire
